// ---- dsc_regs.svh ----
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

// ==========================================================================
// Serial word layout
`define DSC_WORD_W        24
`define DSC_CMD_HI        23
`define DSC_CMD_LO        20
`define DSC_DATA_W        16
`define DSC_CTRL_SEL_HI   1
`define DSC_CTRL_SEL_LO   0
`define DSC_CTRL_OUT_EN   2

// ==========================================================================
// Command codes
`define DSC_CMD_NOP       4'h0
`define DSC_CMD_WR_INPUT  4'h1
`define DSC_CMD_UPDATE    4'h2
`define DSC_CMD_WR_UPDATE 4'h3
`define DSC_CMD_WR_CTRL   4'h4
`define DSC_CMD_FULL_RST  4'hf

// ==========================================================================
// Clear presets and reset values
`define DSC_SEL_ZERO      2'h0
`define DSC_SEL_MID       2'h1
`define DSC_SEL_FULL      2'h2
`define DSC_CODE_ZERO     16'h0000
`define DSC_CODE_MID      16'h8000
`define DSC_CODE_FULL     16'hffff
`define DSC_PIN_W         7
`define DSC_PIN_IDLE      7'h0f
`define DSC_PIN_SYNC      0
`define DSC_PIN_STROBE    1
`define DSC_PIN_CLEAR     2
`define DSC_PIN_RESET     3
`define DSC_PIN_TEMP      4
`define DSC_PIN_SHORT     5
`define DSC_PIN_BROWN     6

// ==========================================================================
// Timing
`define DSC_CLK_NS        4
`define DSC_SCLK_MAX_MHZ  33
`define DSC_T_LEAD_NS     15
`define DSC_T_TAIL_NS     10
`define DSC_T_GAP_NS      50
`define DSC_HALF_CYC  ((500 + `DSC_SCLK_MAX_MHZ * `DSC_CLK_NS - 1) / (`DSC_SCLK_MAX_MHZ * `DSC_CLK_NS))
`define DSC_LEAD_CYC  ((`DSC_T_LEAD_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_TAIL_CYC  ((`DSC_T_TAIL_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_GAP_CYC   ((`DSC_T_GAP_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_DIV_W         4
`define DSC_BITS_W        5

`endif

// ---- dsc_pkg.sv ----
`include "dsc_regs.svh"

package dsc_pkg;

   // ========================================================================
   // Commands
   typedef enum logic [3:0] {
      DSC_NOP       = `DSC_CMD_NOP,
      DSC_WR_INPUT  = `DSC_CMD_WR_INPUT,
      DSC_UPDATE    = `DSC_CMD_UPDATE,
      DSC_WR_UPDATE = `DSC_CMD_WR_UPDATE,
      DSC_WR_CTRL   = `DSC_CMD_WR_CTRL,
      DSC_FULL_RST  = `DSC_CMD_FULL_RST
   } dsc_cmd_type;

   // ========================================================================
   // Host frame states
   typedef enum logic [2:0] {
      DSC_H_IDLE  = 3'b000,
      DSC_H_LEAD  = 3'b001,
      DSC_H_SHIFT = 3'b010,
      DSC_H_TAIL  = 3'b011,
      DSC_H_GAP   = 3'b100
   } dsc_hstate_type;

endpackage

// ---- dsc_link_if.sv ----
`timescale 1ns/1ps

interface dsc_link_if;
   logic sync_n;
   logic sclk;
   logic sdi;
   logic sdo;
   logic output_update_strobe_n;
   logic clear_n;
   logic reset_n;

   modport host (
      output sync_n, sclk, sdi, output_update_strobe_n, clear_n, reset_n,
      input  sdo
   );

   modport device (
      input  sync_n, sclk, sdi, output_update_strobe_n, clear_n, reset_n,
      output sdo
   );
endinterface

// ---- dsc_buf2.sv ----
`timescale 1ns/1ps

module dsc_buf2 #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   // System
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             ce,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [CW-1:0]               count;
      logic                        rdy;
      logic                        vld;
   } dsc_buf_type;

   dsc_buf_type b_reg, b_next;
   logic push, pop;

   function automatic logic [AW-1:0] dsc_wrap(input logic [AW-1:0] p);
      dsc_wrap = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   // ========================================================================
   // Next state
   always_comb begin
      b_next = b_reg;
      push   = in_valid & b_reg.rdy;
      pop    = out_ready & b_reg.vld;
      if (push) begin
         b_next.mem[b_reg.wr] = in_data;
         b_next.wr            = dsc_wrap(b_reg.wr);
      end
      if (pop) begin
         b_next.rd = dsc_wrap(b_reg.rd);
      end
      if (push && !pop) begin
         b_next.count = CW'(b_reg.count + 1'b1);
      end else if (pop && !push) begin
         b_next.count = CW'(b_reg.count - 1'b1);
      end
      b_next.rdy = (b_next.count != CW'(DEPTH));
      b_next.vld = (b_next.count != '0);
   end

   // ========================================================================
   // Registers
   always_ff @(posedge clk) begin
      if (reset) begin
         b_reg     <= '0;
         b_reg.rdy <= 1'b1;
      end else if (ce) begin
         b_reg <= b_next;
      end
   end

   assign in_ready  = b_reg.rdy;
   assign out_valid = b_reg.vld;
   assign out_data  = b_reg.mem[b_reg.rd];
endmodule // dsc_buf2

// ---- dsc_device.sv ----
`timescale 1ns/1ps
`include "dsc_regs.svh"
// ==========================================================================
// Summary of operation
// [RL1] Reset pin low restores clamped powered-down defaults
// [RL2] Output bit shifts out on clock rise
// [RL3] Host samples output bit on clock fall
// [RL4] Host holds input bit stable at fall
// [RL5] Bits taken only while frame select low
// [RL6] Input bits shift in on clock fall
// [RL7] Word acted on at frame select rise
// [RL8] Strobe low: written value updates output at once
// [RL9] Strobe high: hold until strobe falls
// [RL10] Alert low on heat, short or brownout
// [RL11] Alert held low after reset until control write
// [RL12] Clear fall loads chosen preset into output
// [RL13] Clear preset chosen by serial control write

module dsc_device
   import dsc_pkg::*;
(
   // System clock domain
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   ce,
   // Serial link and control pins
   dsc_link_if.device                  link,
   // Fault detectors
   input  wire logic                   over_temp,
   input  wire logic                   out_short,
   input  wire logic                   brownout,
   // Converter side
   output logic [`DSC_DATA_W-1:0]      dac_code,
   output logic [`DSC_DATA_W-1:0]      input_code,
   output logic [1:0]                  clear_sel,
   output logic                        out_clamp,
   output logic                        out_powerdown,
   output logic                        alert_n
);

   // ========================================================================
   // Link domain state
   typedef struct packed {
      logic [`DSC_WORD_W-1:0] shift;
   } dsc_fall_type;

   typedef struct packed {
      logic sdo;
   } dsc_rise_type;

   dsc_fall_type fall_reg, fall_next;
   dsc_rise_type rise_reg, rise_next;

   always_comb begin
      fall_next = fall_reg;
      if (!link.sync_n) begin                                      // [RL5]
         fall_next.shift = {fall_reg.shift[`DSC_WORD_W-2:0], link.sdi}; // [RL6]
      end
   end

   always_ff @(negedge link.sclk) begin
      fall_reg <= fall_next;
   end

   always_comb begin
      rise_next = rise_reg;
      if (!link.sync_n) begin
         rise_next.sdo = fall_reg.shift[`DSC_WORD_W-1];          // [RL2]
      end
   end

   always_ff @(posedge link.sclk) begin
      rise_reg <= rise_next;
   end

   assign link.sdo = rise_reg.sdo;

   // ========================================================================
   // System domain state
   typedef struct packed {
      logic [`DSC_PIN_W-1:0]  meta;
      logic [`DSC_PIN_W-1:0]  pins;
      logic [`DSC_PIN_W-1:0]  pins_d;
      logic [`DSC_DATA_W-1:0] in_code;
      logic [`DSC_DATA_W-1:0] dac_code;
      logic [1:0]             clear_sel;
      logic                   alert_hold;
      logic                   clamp;
      logic                   pdown;
      logic                   alert_n;
   } dsc_dev_type;

   dsc_dev_type d_reg, d_next;
   logic [`DSC_WORD_W-1:0] word;
   dsc_cmd_type            cmd;
   logic [`DSC_DATA_W-1:0] data;
   logic                   frame_end;
   logic                   strobe_fall;
   logic                   strobe_low;
   logic                   clear_fall;
   logic                   fault;

   // Control fields back to power-on values
   function automatic dsc_dev_type dsc_defaults(input dsc_dev_type s);
      dsc_dev_type r;
      r            = s;
      r.in_code    = `DSC_CODE_ZERO;
      r.dac_code   = `DSC_CODE_ZERO;
      r.clear_sel  = `DSC_SEL_ZERO;
      r.alert_hold = 1'b1;
      r.clamp      = 1'b1;
      r.pdown      = 1'b1;
      r.alert_n    = 1'b0;
      return r;
   endfunction

   function automatic logic [`DSC_DATA_W-1:0] dsc_preset(input logic [1:0] sel);
      case (sel)
         `DSC_SEL_MID:  dsc_preset = `DSC_CODE_MID;
         `DSC_SEL_FULL: dsc_preset = `DSC_CODE_FULL;
         default:       dsc_preset = `DSC_CODE_ZERO;
      endcase
   endfunction

   // ========================================================================
   // Next state
   always_comb begin
      d_next        = d_reg;
      d_next.meta   = {brownout, out_short, over_temp, link.reset_n,
                       link.clear_n, link.output_update_strobe_n, link.sync_n};
      d_next.pins   = d_reg.meta;
      d_next.pins_d = d_reg.pins;

      // Word is quiet here: link clock is stopped once frame select is high
      word        = fall_reg.shift;
      cmd         = dsc_cmd_type'(word[`DSC_CMD_HI:`DSC_CMD_LO]);
      data        = word[`DSC_DATA_W-1:0];
      frame_end   = d_reg.pins[`DSC_PIN_SYNC] & ~d_reg.pins_d[`DSC_PIN_SYNC];
      strobe_low  = ~d_reg.pins[`DSC_PIN_STROBE];
      strobe_fall = strobe_low & d_reg.pins_d[`DSC_PIN_STROBE];
      clear_fall  = ~d_reg.pins[`DSC_PIN_CLEAR] & d_reg.pins_d[`DSC_PIN_CLEAR];
      fault       = d_reg.pins[`DSC_PIN_TEMP] | d_reg.pins[`DSC_PIN_SHORT]
                    | d_reg.pins[`DSC_PIN_BROWN];

      if (!d_reg.pins[`DSC_PIN_RESET]) begin
         d_next = dsc_defaults(d_next);                           // [RL1]
      end else begin
         if (strobe_fall) begin
            d_next.dac_code = d_reg.in_code;                      // [RL9]
         end
         if (frame_end) begin                                     // [RL7]
            case (cmd)
               DSC_WR_INPUT: begin
                  d_next.in_code = data;
                  if (strobe_low) begin
                     d_next.dac_code = data;                      // [RL8]
                  end
               end
               DSC_UPDATE: begin
                  d_next.dac_code = d_reg.in_code;
               end
               DSC_WR_UPDATE: begin
                  d_next.in_code  = data;
                  d_next.dac_code = data;
               end
               DSC_WR_CTRL: begin
                  d_next.clear_sel  = data[`DSC_CTRL_SEL_HI:`DSC_CTRL_SEL_LO]; // [RL13]
                  d_next.alert_hold = 1'b0;                       // [RL11]
                  d_next.clamp      = ~data[`DSC_CTRL_OUT_EN];
                  d_next.pdown      = ~data[`DSC_CTRL_OUT_EN];
               end
               DSC_FULL_RST: begin
                  d_next = dsc_defaults(d_next);                  // [RL11]
               end
               default: begin
               end
            endcase
         end
         // Clear wins on the output code, command still kept
         if (clear_fall) begin
            d_next.dac_code = dsc_preset(d_reg.clear_sel);       // [RL12]
         end
      end
      d_next.alert_n = ~(d_next.alert_hold | fault);              // [RL10]
   end

   // ========================================================================
   // Registers
   always_ff @(posedge clk) begin
      if (reset) begin
         d_reg        <= dsc_defaults('0);                        // [RL1]
         d_reg.meta   <= `DSC_PIN_IDLE;
         d_reg.pins   <= `DSC_PIN_IDLE;
         d_reg.pins_d <= `DSC_PIN_IDLE;
      end else if (ce) begin
         d_reg <= d_next;
      end
   end

   // ========================================================================
   // Outputs
   assign dac_code      = d_reg.dac_code;
   assign input_code    = d_reg.in_code;
   assign clear_sel     = d_reg.clear_sel;
   assign out_clamp     = d_reg.clamp;
   assign out_powerdown = d_reg.pdown;
   assign alert_n       = d_reg.alert_n;
endmodule // dsc_device

// ---- dsc_host.sv ----
`timescale 1ns/1ps
`include "dsc_regs.svh"

module dsc_host
   import dsc_pkg::*;
(
   // System
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   ce,
   // Serial link and control pins
   dsc_link_if.host                    link,
   // Words to send
   input  wire logic [`DSC_WORD_W-1:0] tx_data,
   input  wire logic                   tx_valid,
   output logic                        tx_ready,
   // Words shifted back
   output logic [`DSC_WORD_W-1:0]      rx_data,
   output logic                        rx_valid,
   // Control pin requests
   input  wire logic                   update_req,
   input  wire logic                   clear_req,
   input  wire logic                   hw_reset_req
);

   typedef struct packed {
      dsc_hstate_type         state;
      logic [`DSC_DIV_W-1:0]  div;
      logic [`DSC_BITS_W-1:0] bits;
      logic [`DSC_WORD_W-1:0] shift;
      logic [`DSC_WORD_W-1:0] rx;
      logic                   sdo_meta;
      logic                   sdo_s;
      logic                   sync_n;
      logic                   sclk;
      logic                   sdi;
      logic [`DSC_WORD_W-1:0] rx_data;
      logic                   rx_valid;
      logic                   strobe_n;
      logic                   clear_n;
      logic                   reset_n;
   } dsc_host_type;

   dsc_host_type h_reg, h_next;
   logic [`DSC_WORD_W-1:0] b_data;
   logic                   b_valid;
   logic                   b_ready;

   // ========================================================================
   // Word buffer
   dsc_buf2 #(
      .WIDTH (`DSC_WORD_W),
      .DEPTH (2)
   ) i_dsc_buf2 (
      .clk       (clk),
      .reset     (reset),
      .ce        (ce),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (b_data),
      .out_valid (b_valid),
      .out_ready (b_ready)
   );

   assign b_ready = (h_reg.state == DSC_H_IDLE);

   // ========================================================================
   // Frame sequencer
   always_comb begin
      h_next          = h_reg;
      h_next.rx_valid = 1'b0;
      h_next.sdo_meta = link.sdo;
      h_next.sdo_s    = h_reg.sdo_meta;
      h_next.strobe_n = ~update_req;
      h_next.clear_n  = ~clear_req;
      h_next.reset_n  = ~hw_reset_req;
      h_next.div      = `DSC_DIV_W'(h_reg.div + 1'b1);
      case (h_reg.state)
         DSC_H_IDLE: begin
            h_next.div = '0;
            if (b_valid) begin
               h_next.shift  = b_data;
               h_next.sdi    = b_data[`DSC_WORD_W-1];               // [RL4]
               h_next.sync_n = 1'b0;                                // [RL5]
               h_next.bits   = '0;
               h_next.state  = DSC_H_LEAD;
            end
         end
         DSC_H_LEAD: begin
            if (h_reg.div == `DSC_DIV_W'(`DSC_LEAD_CYC - 1)) begin
               h_next.div   = '0;
               h_next.state = DSC_H_SHIFT;
            end
         end
         DSC_H_SHIFT: begin
            if (h_reg.div == `DSC_DIV_W'(`DSC_HALF_CYC - 1)) begin
               h_next.div  = '0;
               h_next.sclk = ~h_reg.sclk;
               if (h_reg.sclk) begin
                  h_next.rx   = {h_reg.rx[`DSC_WORD_W-2:0], h_reg.sdo_s}; // [RL3]
                  h_next.bits = `DSC_BITS_W'(h_reg.bits + 1'b1);
               end else if (h_reg.bits == `DSC_BITS_W'(`DSC_WORD_W)) begin
                  h_next.state = DSC_H_TAIL;
               end else begin
                  h_next.shift = {h_reg.shift[`DSC_WORD_W-2:0], 1'b0};
                  h_next.sdi   = h_reg.shift[`DSC_WORD_W-2];         // [RL4]
               end
            end
         end
         DSC_H_TAIL: begin
            if (h_reg.div == `DSC_DIV_W'(`DSC_TAIL_CYC - 1)) begin
               h_next.div      = '0;
               h_next.sync_n   = 1'b1;                              // [RL5]
               h_next.rx_data  = h_reg.rx;
               h_next.rx_valid = 1'b1;
               h_next.state    = DSC_H_GAP;
            end
         end
         DSC_H_GAP: begin
            if (h_reg.div == `DSC_DIV_W'(`DSC_GAP_CYC - 1)) begin
               h_next.div   = '0;
               h_next.state = DSC_H_IDLE;
            end
         end
         default: begin
            h_next.state = DSC_H_IDLE;
         end
      endcase
   end

   // ========================================================================
   // Registers
   always_ff @(posedge clk) begin
      if (reset) begin
         h_reg          <= '0;
         h_reg.state    <= DSC_H_IDLE;
         h_reg.sync_n   <= 1'b1;
         h_reg.sclk     <= 1'b1;
         h_reg.strobe_n <= 1'b1;
         h_reg.clear_n  <= 1'b1;
         h_reg.reset_n  <= 1'b1;
      end else if (ce) begin
         h_reg <= h_next;
      end
   end

   assign link.sync_n                 = h_reg.sync_n;
   assign link.sclk                   = h_reg.sclk;
   assign link.sdi                    = h_reg.sdi;
   assign link.output_update_strobe_n = h_reg.strobe_n;
   assign link.clear_n                = h_reg.clear_n;
   assign link.reset_n                = h_reg.reset_n;
   assign rx_data                     = h_reg.rx_data;
   assign rx_valid                    = h_reg.rx_valid;
endmodule // dsc_host

// ---- dsc_link_sva.sv ----
`timescale 1ns/1ps

// ==========================================================================
// Link wire checks
module dsc_link_sva (
   // System
   input  wire logic clk,
   input  wire logic reset,
   // Link
   input  wire logic sync_n,
   input  wire logic sclk,
   input  wire logic sdi,
   input  wire logic sdo,
   input  wire logic output_update_strobe_n,
   input  wire logic clear_n,
   input  wire logic reset_n
);

   // ========================================================================
   // Falling edges within a frame
   logic       sclk_q_reg;
   logic [4:0] nfall_reg;

   always_ff @(posedge clk) begin
      sclk_q_reg <= sclk;
      if (reset || sync_n) begin
         nfall_reg <= 5'h00;
      end else if (sclk_q_reg && !sclk) begin
         nfall_reg <= nfall_reg + 5'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ========================================================================
   // Assertions
   sclk_idle_a: assert property (sync_n |-> sclk)
      else $error("serial clock low outside frame");
   fall_in_frame_a: assert property ($fell(sclk) |-> !sync_n)
      else $error("serial clock fell outside frame");
   sdi_stable_a: assert property (!sclk |-> $stable(sdi))
      else $error("serial input moved while clock low");
   lead_time_a: assert property ($fell(sync_n) |-> sclk[*4])
      else $error("frame lead too short");
   low_phase_a: assert property ($fell(sclk) |-> (!sclk)[*4] ##1 sclk)
      else $error("clock low phase wrong");
   high_phase_a: assert property ($rose(sclk) |-> sclk[*4])
      else $error("clock high phase too short");
   bit_count_a: assert property ($rose(sync_n) |-> nfall_reg == 5'h18)
      else $error("frame did not carry 24 bits");
   tail_time_a: assert property ($rose(sync_n) |-> $past(sclk, 3) && $past(sclk, 1))
      else $error("frame closed too soon after last bit");
   frame_gap_a: assert property ($rose(sync_n) |-> sync_n[*8] ##1 sync_n[*5])
      else $error("gap between frames too short");
   sdo_on_rise_a: assert property ($changed(sdo) |-> $rose(sclk))
      else $error("serial output moved off clock rise");

   cover property ($fell(output_update_strobe_n));
   cover property ($fell(clear_n));
   cover property ($fell(reset_n));

endmodule // dsc_link_sva

// ---- tb_dac_serial_and_control_pins.sv ----
`timescale 1ns/1ps
`include "dsc_regs.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end

// ==========================================================================
// Bench top
module tb_dac_serial_and_control_pins;
   import dsc_pkg::*;

   logic                   clk = 1'b0;
   logic                   reset = 1'b1;
   logic [23:0]            tx_data = 24'h000000;
   logic                   tx_valid = 1'b0;
   logic                   tx_ready;
   logic [23:0]            rx_data;
   logic                   rx_valid;
   logic                   update_req = 1'b0;
   logic                   clear_req = 1'b0;
   logic                   hw_reset_req = 1'b0;
   logic [2:0]             faults = 3'h0;
   logic [15:0]            dac_code;
   logic [15:0]            input_code;
   logic [1:0]             clear_sel;
   logic                   out_clamp;
   logic                   out_powerdown;
   logic                   alert_n;
   logic [23:0]            rx_last;
   logic [23:0]            rx_seq [3];
   int                     n_errors = 0;
   int                     total_checks = 0;
   logic [15:0]            presets [4] = '{16'h0000, 16'h8000, 16'hffff, 16'h0000};

   always #2 clk = ~clk;

   dsc_link_if i_dsc_link_if ();

   dsc_host i_dsc_host (.clk(clk), .reset(reset), .ce(1'b1), .link(i_dsc_link_if.host),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .update_req(update_req), .clear_req(clear_req),
      .hw_reset_req(hw_reset_req));

   dsc_device i_dsc_device (.clk(clk), .reset(reset), .ce(1'b1),
      .link(i_dsc_link_if.device), .over_temp(faults[0]), .out_short(faults[1]),
      .brownout(faults[2]), .dac_code(dac_code), .input_code(input_code),
      .clear_sel(clear_sel), .out_clamp(out_clamp), .out_powerdown(out_powerdown),
      .alert_n(alert_n));

   dsc_link_sva i_dsc_link_sva (.clk(clk), .reset(reset), .sync_n(i_dsc_link_if.sync_n),
      .sclk(i_dsc_link_if.sclk), .sdi(i_dsc_link_if.sdi), .sdo(i_dsc_link_if.sdo),
      .output_update_strobe_n(i_dsc_link_if.output_update_strobe_n),
      .clear_n(i_dsc_link_if.clear_n), .reset_n(i_dsc_link_if.reset_n));

   // =======================================================================
   // Access tasks
   task automatic push(input logic [23:0] w);
      int n;
      @(negedge clk);
      tx_data = w;
      tx_valid = 1'b1;
      for (n = 0; n < 600 && tx_ready !== 1'b1; n++) @(negedge clk);
      if (n == 600) n_errors++;
      @(negedge clk);
      tx_valid = 1'b0;
   endtask

   task automatic frame(output logic [23:0] rx);
      int n;
      for (n = 0; n < 800 && rx_valid !== 1'b1; n++) @(negedge clk);
      if (n == 800) n_errors++;
      rx = rx_data;
      @(negedge clk);
   endtask

   task automatic send(input logic [3:0] cmd, input logic [15:0] d);
      push({cmd, 4'h0, d});
      frame(rx_last);
      repeat (8) @(negedge clk);
   endtask

   task automatic ctrl(input logic [1:0] sel);
      send(`DSC_CMD_WR_CTRL, {13'h0000, 1'b1, sel});
   endtask

   task automatic pin(ref logic p);
      @(negedge clk);
      p = 1'b1;
      repeat (6) @(negedge clk);
      p = 1'b0;
      repeat (8) @(negedge clk);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // =======================================================================
   // Tests
   initial begin
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("dac_code", 16'h0000, dac_code)
      `CHK("out_clamp", 1'b1, out_clamp)
      `CHK("out_powerdown", 1'b1, out_powerdown)
      `CHK("alert_n", 1'b0, alert_n)
      $display("test reset_defaults done");
      ctrl(`DSC_SEL_MID);
      `CHK("alert_n", 1'b1, alert_n)
      `CHK("out_clamp", 1'b0, out_clamp)
      `CHK("clear_sel", `DSC_SEL_MID, clear_sel)
      $display("test control_write done");
      update_req = 1'b1;
      send(`DSC_CMD_WR_INPUT, 16'h1234);
      `CHK("dac_code", 16'h1234, dac_code)
      update_req = 1'b0;
      send(`DSC_CMD_WR_INPUT, 16'ha5a5);
      `CHK("input_code", 16'ha5a5, input_code)
      `CHK("dac_code", 16'h1234, dac_code)
      pin(update_req);
      `CHK("dac_code", 16'ha5a5, dac_code)
      send(`DSC_CMD_WR_INPUT, 16'h0f0f);
      `CHK("dac_code", 16'ha5a5, dac_code)
      send(`DSC_CMD_UPDATE, 16'h0000);
      `CHK("dac_code", 16'h0f0f, dac_code)
      $display("test update_strobe done");
      for (int s = 0; s < 4; s++) begin
         ctrl(s[1:0]);
         send(`DSC_CMD_WR_UPDATE, 16'h5a5a);
         pin(clear_req);
         `CHK("dac_code", presets[s], dac_code)
      end
      $display("test clear_presets done");
      push(24'h0abcde);
      push(24'h012345);
      push(24'h06789a);
      for (int i = 0; i < 3; i++) frame(rx_seq[i]);
      `CHK("rx_data", 24'h305a5a, rx_seq[0])
      `CHK("rx_data", 24'h0abcde, rx_seq[1])
      `CHK("rx_data", 24'h012345, rx_seq[2])
      $display("test daisy_chain done");
      for (int i = 0; i < 3; i++) begin
         @(negedge clk);
         faults = 3'h1 << i;
         repeat (8) @(negedge clk);
         `CHK("alert_n", 1'b0, alert_n)
         faults = 3'h0;
         repeat (8) @(negedge clk);
         `CHK("alert_n", 1'b1, alert_n)
      end
      $display("test fault_alert done");
      pin(hw_reset_req);
      `CHK("dac_code", 16'h0000, dac_code)
      `CHK("out_powerdown", 1'b1, out_powerdown)
      `CHK("alert_n", 1'b0, alert_n)
      ctrl(`DSC_SEL_FULL);
      send(`DSC_CMD_WR_UPDATE, 16'h7777);
      send(`DSC_CMD_FULL_RST, 16'h0000);
      `CHK("alert_n", 1'b0, alert_n)
      `CHK("dac_code", 16'h0000, dac_code)
      $display("test resets done");
      report_and_stop();
   end

   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end

endmodule // tb_dac_serial_and_control_pins
